// [bia_defines.svh]
/*
 * Constants for the integer execute datapath and immediate generator.
 * Assumes a 32-bit instruction word with register specifiers at fixed
 * positions in every format.
 */
// Contract
// - branch offset reuses store layout, inst7 high
// - upper shifted by twelve, jump by one
// - every immediate sign comes from inst31
// - arithmetic never traps or flags overflow
// - immediate and register forms write destination
// - add immediate keeps low register-width bits
// - set-below immediate, signed and unsigned compare
// - bitwise and, or, xor with immediate
// - constant shift amount five bits, bit30 selects
// - shift fills zeros or copies sign
// - load upper writes immediate, low zeros
// - pc plus upper immediate to destination
// - register ops select by both function fields
// - register add and subtract, wrap around
// - register set-below, signed and unsigned
// - register bitwise and, or, xor
// - register shift uses low five bits
// - canonical no-op changes no state
// - no delay slot after taken transfer
// - target fetch fault reported on target
// - zero register reads zero, writes dropped
// - thirty-two registers of 32 bits
`ifndef BIA_DEFINES_SVH
`define BIA_DEFINES_SVH
`define BIA_REG_WIDTH   32
`define BIA_NREGS       32
`define BIA_RIDX_W      5
`define BIA_SHAMT_W     5
`define BIA_OP_IMM      7'h13
`define BIA_OP_REG      7'h33
`define BIA_OP_LUI      7'h37
`define BIA_OP_AUIPC    7'h17
`define BIA_F3_ADD      3'h0
`define BIA_F3_SHL      3'h1
`define BIA_F3_SLT      3'h2
`define BIA_F3_LTU      3'h3
`define BIA_F3_XOR      3'h4
`define BIA_F3_SR       3'h5
`define BIA_F3_OR       3'h6
`define BIA_F3_AND      3'h7
`define BIA_F7_BASE     7'h00
`define BIA_F7_ALT      7'h20
`define BIA_NOP_WORD    32'h00000013
`define BIA_ZERO_IDX    5'h00
`define BIA_ONE         32'h00000001
`define BIA_ZERO        32'h00000000
`endif

// [bia_pkg.sv]
/*
 * Types for the integer execute datapath.
 * Assumes the defines header is compiled alongside.
 */
package bia_pkg;
  typedef enum logic [3:0] {
    BIA_ALU_ADD  = 4'h0,
    BIA_ALU_SUB  = 4'h1,
    BIA_ALU_SLT  = 4'h2,
    BIA_ALU_LTU  = 4'h3,
    BIA_ALU_XOR  = 4'h4,
    BIA_ALU_OR   = 4'h5,
    BIA_ALU_AND  = 4'h6,
    BIA_ALU_SHL  = 4'h7,
    BIA_ALU_SHR  = 4'h8,
    BIA_ALU_ASR  = 4'h9,
    BIA_ALU_PASS = 4'hA
  } bia_alu_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] inst;
    logic [31:0] pc;
    logic        fetch_fault;
  } bia_issue_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  rd;
    logic [31:0] data;
  } bia_wb_t;
endpackage

// [bia_alu.sv]
/*
 * Immediate generator, integer execute unit and register file.
 * Assumes the decoder issues one instruction per cycle with its pc, and
 * flushes the slot after a taken transfer through flush_in.
 */
`include "bia_defines.svh"
module bia_alu
  import bia_pkg::*;
#(
  parameter int REG_WIDTH = `BIA_REG_WIDTH,
  parameter int NREGS     = `BIA_NREGS
) (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  // issue from decoder
  input  wire bia_issue_t           issue_in,
  input  wire logic                 flush_in,
  // register read port for the outside
  input  wire logic [4:0]           dbg_idx_in,
  output logic      [REG_WIDTH-1:0] dbg_data_out,
  // writeback and status
  output bia_wb_t                   wb_out,
  output logic                      fault_out,
  output logic      [31:0]          fault_pc_out,
  output logic                      illegal_out
);

  // ****************************************
  // immediate generation
  // ****************************************
  logic [31:0] inst;
  logic [6:0]  opcode;
  logic [2:0]  lower_function_select;
  logic [6:0]  upper_function_select;
  logic [4:0]  first_source_register;
  logic [4:0]  second_source_register;
  logic [4:0]  dest_reg;
  logic [31:0] imm_reg_form;
  logic [31:0] imm_store_form;
  logic [31:0] imm_branch_form;
  logic [31:0] imm_upper_form;
  logic [31:0] imm_jump_form;

  assign inst                   = issue_in.inst;
  assign opcode                 = inst[6:0];
  assign dest_reg               = inst[11:7];
  assign lower_function_select  = inst[14:12];
  assign first_source_register  = inst[19:15];
  assign second_source_register = inst[24:20];
  assign upper_function_select  = inst[31:25];

  assign imm_reg_form    = {{20{inst[31]}}, inst[31:20]};
  assign imm_store_form  = {{20{inst[31]}}, inst[31:25], inst[11:7]};
  assign imm_branch_form = {{19{inst[31]}}, inst[31], inst[7], inst[30:25], inst[11:8], 1'b0};
  assign imm_upper_form  = {inst[31:12], 12'h000};
  assign imm_jump_form   = {{11{inst[31]}}, inst[31], inst[19:12], inst[20], inst[30:21], 1'b0};

  // ****************************************
  // register file
  // ****************************************
  logic [REG_WIDTH-1:0] regs_ff [NREGS];
  logic [REG_WIDTH-1:0] nxt_regs [NREGS];

  function automatic logic [REG_WIDTH-1:0] rd_reg(input logic [4:0] idx, input logic [REG_WIDTH-1:0] r [NREGS]);
    rd_reg = (idx == `BIA_ZERO_IDX) ? '0 : r[idx];
  endfunction

  logic [REG_WIDTH-1:0] src_a;
  logic [REG_WIDTH-1:0] src_b;
  assign src_a        = rd_reg(first_source_register, regs_ff);
  assign src_b        = rd_reg(second_source_register, regs_ff);
  assign dbg_data_out = rd_reg(dbg_idx_in, regs_ff);

  // ****************************************
  // decode
  // ****************************************
  bia_alu_t             alu_op;
  logic [REG_WIDTH-1:0] opnd_a;
  logic [REG_WIDTH-1:0] opnd_b;
  logic                 writes;
  logic                 bad;

  always_comb begin
    alu_op = BIA_ALU_ADD;
    opnd_a = src_a;
    opnd_b = imm_reg_form;
    writes = 1'b0;
    bad    = 1'b0;
    unique case (opcode)
      `BIA_OP_IMM: begin
        writes = 1'b1;
        unique case (lower_function_select)
          `BIA_F3_ADD:  alu_op = BIA_ALU_ADD;
          `BIA_F3_SLT:  alu_op = BIA_ALU_SLT;
          `BIA_F3_LTU:  alu_op = BIA_ALU_LTU;
          `BIA_F3_XOR:  alu_op = BIA_ALU_XOR;
          `BIA_F3_OR:   alu_op = BIA_ALU_OR;
          `BIA_F3_AND:  alu_op = BIA_ALU_AND;
          `BIA_F3_SHL:  alu_op = BIA_ALU_SHL;
          `BIA_F3_SR:   alu_op = inst[30] ? BIA_ALU_ASR : BIA_ALU_SHR;
          default:      alu_op = BIA_ALU_ADD;
        endcase
      end
      `BIA_OP_REG: begin
        writes = 1'b1;
        opnd_b = src_b;
        unique case (lower_function_select)
          `BIA_F3_ADD:  alu_op = (upper_function_select == `BIA_F7_ALT) ? BIA_ALU_SUB : BIA_ALU_ADD;
          `BIA_F3_SLT:  alu_op = BIA_ALU_SLT;
          `BIA_F3_LTU:  alu_op = BIA_ALU_LTU;
          `BIA_F3_XOR:  alu_op = BIA_ALU_XOR;
          `BIA_F3_OR:   alu_op = BIA_ALU_OR;
          `BIA_F3_AND:  alu_op = BIA_ALU_AND;
          `BIA_F3_SHL:  alu_op = BIA_ALU_SHL;
          `BIA_F3_SR:   alu_op = (upper_function_select == `BIA_F7_ALT) ? BIA_ALU_ASR : BIA_ALU_SHR;
          default:      alu_op = BIA_ALU_ADD;
        endcase
        if (upper_function_select != `BIA_F7_BASE &&
            !(upper_function_select == `BIA_F7_ALT &&
              (lower_function_select == `BIA_F3_ADD || lower_function_select == `BIA_F3_SR))) begin
          writes = 1'b0;
          bad    = 1'b1;
        end
      end
      `BIA_OP_LUI: begin
        writes = 1'b1;
        alu_op = BIA_ALU_PASS;
        opnd_b = imm_upper_form;
      end
      `BIA_OP_AUIPC: begin
        writes = 1'b1;
        alu_op = BIA_ALU_ADD;
        opnd_a = issue_in.pc;
        opnd_b = imm_upper_form;
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  // ****************************************
  // execute
  // ****************************************
  logic [REG_WIDTH-1:0] result;
  logic [4:0]           shamt;
  assign shamt = opnd_b[`BIA_SHAMT_W-1:0];

  // results wrap; no overflow signal exists at all
  always_comb begin
    unique case (alu_op)
      BIA_ALU_ADD:  result = opnd_a + opnd_b;
      BIA_ALU_SUB:  result = opnd_a - opnd_b;
      BIA_ALU_SLT:  result = ($signed(opnd_a) < $signed(opnd_b)) ? `BIA_ONE : `BIA_ZERO;
      BIA_ALU_LTU:  result = (opnd_a < opnd_b) ? `BIA_ONE : `BIA_ZERO;
      BIA_ALU_XOR:  result = opnd_a ^ opnd_b;
      BIA_ALU_OR:   result = opnd_a | opnd_b;
      BIA_ALU_AND:  result = opnd_a & opnd_b;
      BIA_ALU_SHL:  result = opnd_a << shamt;
      BIA_ALU_SHR:  result = opnd_a >> shamt;
      BIA_ALU_ASR:  result = REG_WIDTH'($signed(opnd_a) >>> shamt);
      BIA_ALU_PASS: result = opnd_b;
      default:      result = '0;
    endcase
  end

  // ****************************************
  // commit
  // ****************************************
  bia_wb_t     nxt_wb;
  logic        fault_ff;
  logic        nxt_fault;
  logic [31:0] fault_pc_ff;
  logic [31:0] nxt_fault_pc;
  logic        illegal_ff;
  logic        nxt_illegal;
  logic        live;
  bia_wb_t     wb_ff;

  // a flushed slot is the one after a taken transfer
  assign live = issue_in.valid && !flush_in;

  always_comb begin
    nxt_wb       = '0;
    nxt_fault    = 1'b0;
    nxt_fault_pc = fault_pc_ff;
    nxt_illegal  = 1'b0;
    nxt_regs     = regs_ff;
    if (live && issue_in.fetch_fault) begin
      nxt_fault    = 1'b1;
      nxt_fault_pc = issue_in.pc;
    end else if (live) begin
      nxt_illegal = bad;
      if (writes && dest_reg != `BIA_ZERO_IDX) begin
        nxt_wb.valid      = 1'b1;
        nxt_wb.rd         = dest_reg;
        nxt_wb.data       = result;
        nxt_regs[dest_reg] = result;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wb_ff       <= '0;
      fault_ff    <= 1'b0;
      fault_pc_ff <= '0;
      illegal_ff  <= 1'b0;
      for (int i = 0; i < NREGS; i++) begin
        regs_ff[i] <= '0;
      end
    end else begin
      wb_ff       <= nxt_wb;
      fault_ff    <= nxt_fault;
      fault_pc_ff <= nxt_fault_pc;
      illegal_ff  <= nxt_illegal;
      regs_ff     <= nxt_regs;
    end
  end

  assign wb_out       = wb_ff;
  assign fault_out    = fault_ff;
  assign fault_pc_out = fault_pc_ff;
  assign illegal_out  = illegal_ff;

  // ****************************************
  // checks
  // ****************************************
  property p_nop_quiet;
    @(posedge clk_in) disable iff (!rstn_in)
    (issue_in.valid && issue_in.inst == `BIA_NOP_WORD) |=> !wb_out.valid;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("no-op wrote a register");

  property p_zero_reads_zero;
    @(posedge clk_in) disable iff (!rstn_in)
    (dbg_idx_in == `BIA_ZERO_IDX) |-> (dbg_data_out == '0);
  endproperty
  a_zero_reads_zero: assert property (p_zero_reads_zero) else $error("zero register not zero");

  sequence s_flushed_slot;
    flush_in;
  endsequence
  sequence s_no_effect;
    !wb_out.valid && !fault_out && !illegal_out;
  endsequence
  property p_flush_no_wb;
    @(posedge clk_in) disable iff (!rstn_in)
    s_flushed_slot |=> s_no_effect;
  endproperty
  a_flush_no_wb: assert property (p_flush_no_wb) else $error("flushed slot had effect");

  property p_fault_on_target;
    @(posedge clk_in) disable iff (!rstn_in)
    (live && issue_in.fetch_fault) |=> fault_out && !wb_out.valid && fault_pc_out == $past(issue_in.pc);
  endproperty
  a_fault_on_target: assert property (p_fault_on_target) else $error("fault not on target");

  property p_add_wraps;
    @(posedge clk_in) disable iff (!rstn_in)
    (live && !issue_in.fetch_fault && opcode == `BIA_OP_REG && lower_function_select == `BIA_F3_ADD &&
     upper_function_select == `BIA_F7_BASE && dest_reg != `BIA_ZERO_IDX)
    |=> wb_out.data == REG_WIDTH'($past(src_a) + $past(src_b));
  endproperty
  a_add_wraps: assert property (p_add_wraps) else $error("register add wrong");

  property p_lui_low_zero;
    @(posedge clk_in) disable iff (!rstn_in)
    (live && !issue_in.fetch_fault && opcode == `BIA_OP_LUI && dest_reg != `BIA_ZERO_IDX)
    |=> wb_out.valid && wb_out.data[11:0] == 12'h000;
  endproperty
  a_lui_low_zero: assert property (p_lui_low_zero) else $error("upper constant low bits set");

  property p_slt_bool;
    @(posedge clk_in) disable iff (!rstn_in)
    (live && !issue_in.fetch_fault && (alu_op == BIA_ALU_SLT || alu_op == BIA_ALU_LTU) && writes &&
     dest_reg != `BIA_ZERO_IDX) |=> wb_out.data[REG_WIDTH-1:1] == '0;
  endproperty
  a_slt_bool: assert property (p_slt_bool) else $error("compare result not boolean");

  property p_commit_next;
    @(posedge clk_in) disable iff (!rstn_in)
    wb_out.valid |-> regs_ff[wb_out.rd] == wb_out.data;
  endproperty
  a_commit_next: assert property (p_commit_next) else $error("register not committed");

  property p_sign_bit;
    @(posedge clk_in) disable iff (!rstn_in)
    imm_reg_form[31] == inst[31] && imm_branch_form[31] == inst[31] && imm_jump_form[31] == inst[31] &&
    imm_store_form[31] == inst[31] && imm_branch_form[11] == inst[7];
  endproperty
  a_sign_bit: assert property (p_sign_bit) else $error("immediate sign wrong");

  // branch offset is the store layout with its lowest bit moved up
  property p_branch_from_store;
    @(posedge clk_in) disable iff (!rstn_in)
    imm_branch_form[10:1] == imm_store_form[10:1] && imm_branch_form[11] == imm_store_form[0] &&
    imm_branch_form[0] == 1'b0 && imm_branch_form[31:12] == imm_store_form[31:12];
  endproperty
  a_branch_from_store: assert property (p_branch_from_store) else $error("branch offset layout wrong");

  // upper field sits twelve places up, the jump field one place up
  property p_upper_jump_place;
    @(posedge clk_in) disable iff (!rstn_in)
    imm_upper_form[11:0] == 12'h000 && imm_upper_form[31:12] == inst[31:12] &&
    imm_jump_form[0] == 1'b0 && imm_jump_form[19:12] == imm_upper_form[19:12] &&
    imm_jump_form[31:20] == {12{inst[31]}};
  endproperty
  a_upper_jump_place: assert property (p_upper_jump_place) else $error("upper or jump offset wrong");
endmodule

// [bia_issuer.sv]
/*
 * Decoder-side model that issues instructions to the datapath.
 * Assumes the bench calls send and rest from one process only.
 */
module bia_issuer
  import bia_pkg::*;
(
  // clock
  input  wire logic clk_in,
  // issue toward the datapath
  output bia_issue_t issue_out,
  output logic       flush_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    issue_out = '0;
    flush_out = 1'b0;
  end
  // one issue per call, driven just after the next rising edge and taken at the one after
  task automatic send(input logic [31:0] inst, input logic [31:0] pc, input logic ff, input logic fl);
    @(posedge clk_in);
    #1;
    issue_out.valid       = 1'b1;
    issue_out.inst        = inst;
    issue_out.pc          = pc;
    issue_out.fetch_fault = ff;
    flush_out             = fl;
  endtask
  // idle slot: word is scrambled so stale data cannot be reused
  task automatic rest();
    @(posedge clk_in);
    #1;
    issue_out.valid = 1'b0;
    issue_out.inst  = ~issue_out.inst;
    flush_out       = 1'b0;
  endtask
endmodule

// [base_integer_alu_immgen_test.sv]
/*
 * Self-checking bench for the integer execute datapath.
 * Assumes results appear on wb_out just after the taking edge, registered on that same edge.
 */
`include "bia_defines.svh"
module base_integer_alu_immgen_test
  import bia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in;
  logic        rstn_in;
  bia_issue_t  issue;
  logic        flush;
  logic [4:0]  dbg_idx;
  logic [31:0] dbg_data_out;
  bia_wb_t     wb;
  logic        fault_out;
  logic [31:0] fault_pc_out;
  logic        illegal_out;
  int          bad_count;
  int          comparisons;
  bia_issuer u_dec (.clk_in(clk_in), .issue_out(issue), .flush_out(flush));
  bia_alu dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .issue_in(issue), .flush_in(flush),
    .dbg_idx_in(dbg_idx), .dbg_data_out(dbg_data_out), .wb_out(wb),
    .fault_out(fault_out), .fault_pc_out(fault_pc_out), .illegal_out(illegal_out)
  );
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] fi(logic [11:0] im, logic [4:0] s, logic [2:0] f, logic [4:0] d);
    fi = {im, s, f, d, `BIA_OP_IMM};
  endfunction
  function automatic logic [31:0] fr(logic [6:0] g, logic [4:0] t, logic [4:0] s, logic [2:0] f, logic [4:0] d);
    fr = {g, t, s, f, d, `BIA_OP_REG};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [4:0] i, input logic [31:0] e);
    @(posedge clk_in);
    #1;
    dbg_idx = i;
    #1;
    chk("register", e, dbg_data_out);
  endtask
  task automatic run(input logic [31:0] inst, input logic [31:0] e);
    u_dec.send(inst, 32'h00000100, 1'b0, 1'b0);
    u_dec.rest();
    chk("wb valid", 32'h00000001, 32'(wb.valid));
    chk("wb rd", 32'(inst[11:7]), 32'(wb.rd));
    chk("wb data", e, wb.data);
    chk("illegal", 32'h00000000, 32'(illegal_out));
    chk("fault", 32'h00000000, 32'(fault_out));
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_alu();
    run(fi(12'hFFF, 5'h00, 3'h0, 5'h01), 32'hFFFFFFFF);
    run(fi(12'h7FF, 5'h00, 3'h0, 5'h02), 32'h000007FF);
    run(fi(12'h001, 5'h01, 3'h2, 5'h03), 32'h00000001);
    run(fi(12'h001, 5'h01, 3'h3, 5'h03), 32'h00000000);
    run(fi(12'hFFF, 5'h00, 3'h3, 5'h03), 32'h00000001);
    run(fi(12'h800, 5'h01, 3'h7, 5'h03), 32'hFFFFF800);
    run(fi(12'h800, 5'h02, 3'h6, 5'h03), 32'hFFFFFFFF);
    run(fi(12'hFFF, 5'h02, 3'h4, 5'h03), 32'hFFFFF800);
    run(fi(12'h01F, 5'h01, 3'h1, 5'h03), 32'h80000000);
    run(fi(12'h004, 5'h03, 3'h5, 5'h04), 32'h08000000);
    run(fi(12'h404, 5'h03, 3'h5, 5'h04), 32'hF8000000);
    run({20'h80001, 5'h06, `BIA_OP_LUI}, 32'h80001000);
    run({20'h00001, 5'h07, `BIA_OP_AUIPC}, 32'h00001100);
    run(fr(7'h00, 5'h02, 5'h01, 3'h0, 5'h08), 32'h000007FE);
    run(fr(7'h20, 5'h01, 5'h02, 3'h0, 5'h08), 32'h00000800);
    run(fr(7'h00, 5'h02, 5'h01, 3'h2, 5'h08), 32'h00000001);
    run(fr(7'h00, 5'h02, 5'h01, 3'h3, 5'h08), 32'h00000000);
    run(fr(7'h00, 5'h02, 5'h01, 3'h7, 5'h08), 32'h000007FF);
    run(fr(7'h00, 5'h02, 5'h01, 3'h6, 5'h08), 32'hFFFFFFFF);
    run(fr(7'h00, 5'h02, 5'h01, 3'h4, 5'h08), 32'hFFFFF800);
    run(fr(7'h00, 5'h01, 5'h02, 3'h1, 5'h08), 32'h80000000);
    run(fr(7'h00, 5'h01, 5'h03, 3'h5, 5'h08), 32'h00000001);
    run(fr(7'h20, 5'h01, 5'h03, 3'h5, 5'h08), 32'hFFFFFFFF);
    rd(5'h01, 32'hFFFFFFFF);
    $display("test alu done");
  endtask
  task automatic t_refuse();
    u_dec.send(`BIA_NOP_WORD, 32'h00000100, 1'b0, 1'b0);
    u_dec.rest();
    chk("nop wb", 32'h00000000, 32'(wb.valid));
    u_dec.send(fi(12'h005, 5'h01, 3'h0, 5'h00), 32'h00000104, 1'b0, 1'b0);
    u_dec.rest();
    chk("zero wb", 32'h00000000, 32'(wb.valid));
    rd(5'h00, 32'h00000000);
    u_dec.send(fi(12'h005, 5'h00, 3'h0, 5'h09), 32'h00000108, 1'b0, 1'b1);
    u_dec.rest();
    chk("flush wb", 32'h00000000, 32'(wb.valid));
    u_dec.send(fr(7'h01, 5'h02, 5'h01, 3'h0, 5'h09), 32'h0000010C, 1'b0, 1'b0);
    u_dec.rest();
    chk("illegal", 32'h00000001, 32'(illegal_out));
    chk("illegal wb", 32'h00000000, 32'(wb.valid));
    u_dec.send(fi(12'h003, 5'h00, 3'h0, 5'h0B), 32'h00000200, 1'b1, 1'b0);
    u_dec.rest();
    chk("fault", 32'h00000001, 32'(fault_out));
    chk("fault pc", 32'h00000200, fault_pc_out);
    chk("fault wb", 32'h00000000, 32'(wb.valid));
    rd(5'h09, 32'h00000000);
    rd(5'h0B, 32'h00000000);
    $display("test refuse done");
  endtask
  task automatic t_chain();
    u_dec.send(fi(12'h001, 5'h00, 3'h0, 5'h09), 32'h00000300, 1'b0, 1'b0);
    u_dec.send(fi(12'h001, 5'h09, 3'h0, 5'h0A), 32'h00000304, 1'b0, 1'b0);
    u_dec.rest();
    chk("chain wb", 32'h00000002, wb.data);
    rd(5'h0A, 32'h00000002);
    $display("test chain done");
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    bad_count++;
    close_out();
  end
  initial begin
    rstn_in     = 1'b0;
    dbg_idx     = 5'h00;
    bad_count   = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    chk("reset wb", 32'h00000000, 32'(wb.valid));
    chk("reset fault pc", 32'h00000000, fault_pc_out);
    chk("reset flags", 32'h00000000, 32'({fault_out, illegal_out}));
    t_alu();
    t_refuse();
    t_chain();
    close_out();
  end
endmodule
